// ==== rtl/pcg_clock_gating.sv ====
// pcg_clock_gating.sv
// peripheral clock gating: gate register, auxiliary divider control, status
// assumes one-cycle access pulses from the peripheral bus decode and a mode input
//
// Operation
// - after reset the gate register reads 0x0000001F
// - global gate bit 5 set stops every peripheral clock
// - any peripheral access while global gate set clears it
// - reading gate register while global set clears it, bit reads 0
// - bit 4 gates the divided gpio clock, 1 blocks
// - hibernate holds divided clock off, gate works in run modes only
// - gpio gate bit never clears by itself
// - divider count written while gpio gate set is not applied
// - bit 3 gates i2c universal clock, 1 disables
// - hibernate keeps i2c clock off, bit writes ignored there
// - i2c register access clears i2c gate bit
// - bit 2 gates timer 2 clock, 1 disables
// - hibernate keeps timer 2 off; timer 2 access clears its bit
// - bits 31 to 6 of gate register read zero
// - divided rate is root over count; 0,1 give 1, above 32 give 32
`timescale 1ns/100ps

module pcg_clock_gating
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // power mode
  input  pcg_mode_t        i_power_mode,
  // peripheral access pulses
  input  wire logic        i_periph_access,
  input  wire logic        i_i2c_access,
  input  wire logic        i_timer2_access,
  // clock enables
  output logic             o_periph_clk_en,
  output logic             o_gpio_clk_en,
  output logic             o_i2c_clk_en,
  output logic             o_timer2_clk_en
);

  // ====================================================================
  // functions

  // saturate the written count to the ratio the divider can run
  function automatic logic [5:0] div_ratio(input logic [7:0] count);
    logic [5:0] r;
    r = `PCG_RATIO_MIN;
    if (count > 8'h20)
    begin
      r = `PCG_RATIO_MAX;
    end
    else if (count > 8'h01)
    begin
      r = count[5:0];
    end
    return r;
  endfunction

  // one clock runs only when its gate, the global gate and hibernate allow
  function automatic logic clock_on(
    input logic own_gate,
    input logic all_gate,
    input logic hib
  );
    return !own_gate && !all_gate && !hib;
  endfunction

  // gate register as software sees it
  function automatic logic [31:0] gate_word(input logic [5:0] gate);
    logic [31:0] w;
    w      = 32'h0000_0000;
    w[4:0] = gate[4:0];
    // the global bit always reads 0: a read while it is set clears it
    w[`PCG_ALL_BIT] = 1'b0;
    return w;
  endfunction

  // divider register as software sees it, other fields read zero
  function automatic logic [31:0] div_word(input logic [7:0] count);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`PCG_DIVCNT_MSB:`PCG_DIVCNT_LSB] = count;
    return w;
  endfunction

  // ====================================================================
  // state

  pcg_state_t st;
  pcg_state_t next_st;

  logic       div_tick;
  logic       hib;
  logic       gate_hit;
  logic       div_hit;
  logic       stat_hit;
  logic       all_off;
  logic       wake;
  logic       bus_wr;
  logic [31:0] stat_word;

  // ====================================================================
  // divider for the gpio clock

  pcg_divider u_div
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_run    (st.gpio_en),
    .i_load   (st.ratio_load),
    .i_ratio  (st.ratio),
    .o_tick   (div_tick)
  );

  // ====================================================================
  // next state

  always_comb
  begin
    next_st            = st;
    next_st.ratio_load = 1'b0;
    next_st.rdata      = 32'h0000_0000;

    hib      = (i_power_mode == PCG_HIBERNATE);
    gate_hit = (i_addr == `PCG_GATE_ADDR);
    div_hit  = (i_addr == `PCG_DIV_ADDR);
    stat_hit = (i_addr == `PCG_STAT_ADDR);
    all_off  = st.gate[`PCG_ALL_BIT];

    // any access, ours or another peripheral's, ends the global gate
    wake = all_off && (i_periph_access || i_i2c_access || i_timer2_access
                       || i_wr || i_rd);

    // the write that wakes the clocks is itself dropped
    bus_wr = i_wr && !all_off;

    // ------------------------------------------------------------
    // status word
    stat_word = 32'h0000_0000;
    stat_word[`PCG_ST_PERIPH_BIT] = st.periph_en;
    stat_word[`PCG_ST_GPIO_BIT]   = st.gpio_en;
    stat_word[`PCG_ST_I2C_BIT]    = st.i2c_en;
    stat_word[`PCG_ST_TMR2_BIT]   = st.tmr2_en;
    stat_word[`PCG_ST_HIB_BIT]    = hib;
    stat_word[`PCG_ST_RATIO_MSB:`PCG_ST_RATIO_LSB] = st.ratio;
    stat_word[`PCG_ST_COUNT_MSB:`PCG_ST_COUNT_LSB] = st.div_count;

    // ------------------------------------------------------------
    // gate register write
    if (bus_wr && gate_hit)
    begin
      next_st.gate[`PCG_ALL_BIT]  = i_wdata[`PCG_ALL_BIT];
      next_st.gate[`PCG_GPIO_BIT] = i_wdata[`PCG_GPIO_BIT];
      next_st.gate[1:0]           = i_wdata[1:0];
      if (!hib)
      begin
        next_st.gate[`PCG_I2C_BIT]  = i_wdata[`PCG_I2C_BIT];
        next_st.gate[`PCG_TMR2_BIT] = i_wdata[`PCG_TMR2_BIT];
      end
    end

    // ------------------------------------------------------------
    // divider register write
    if (bus_wr && div_hit)
    begin
      next_st.div_count = i_wdata[`PCG_DIVCNT_MSB:`PCG_DIVCNT_LSB];
      // a count written behind a closed gate is kept but never applied
      if (!st.gate[`PCG_GPIO_BIT])
      begin
        next_st.ratio      = div_ratio(i_wdata[`PCG_DIVCNT_MSB:`PCG_DIVCNT_LSB]);
        next_st.ratio_load = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // hardware clears; these win over a write in the same cycle
    // because the accessing peripheral needs its clock back
    if (i_i2c_access)
    begin
      next_st.gate[`PCG_I2C_BIT] = 1'b0;
    end
    if (i_timer2_access)
    begin
      next_st.gate[`PCG_TMR2_BIT] = 1'b0;
    end
    if (wake)
    begin
      next_st.gate[`PCG_ALL_BIT] = 1'b0;
    end

    // ------------------------------------------------------------
    // read data, valid in the cycle after the strobe only
    if (i_rd)
    begin
      if (gate_hit)
      begin
        next_st.rdata = gate_word(st.gate);
      end
      else if (div_hit)
      begin
        next_st.rdata = div_word(st.div_count);
      end
      else if (stat_hit)
      begin
        next_st.rdata = stat_word;
      end
      else
      begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    // ------------------------------------------------------------
    // clock enables are registered from the next gates, so they change with the stored gates
    next_st.periph_en = !next_st.gate[`PCG_ALL_BIT] && !hib;
    next_st.gpio_en   = clock_on(next_st.gate[`PCG_GPIO_BIT],
                                 next_st.gate[`PCG_ALL_BIT], hib);
    next_st.i2c_en    = clock_on(next_st.gate[`PCG_I2C_BIT],
                                 next_st.gate[`PCG_ALL_BIT], hib);
    next_st.tmr2_en   = clock_on(next_st.gate[`PCG_TMR2_BIT],
                                 next_st.gate[`PCG_ALL_BIT], hib);

    // the divided rate is passed only while the gpio clock may run
    next_st.gpio_tick = div_tick && st.gpio_en && next_st.gpio_en;
  end

  // ====================================================================
  // registers

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st.gate       <= `PCG_GATE_RESET;
      st.div_count  <= `PCG_DIVCNT_RESET;
      st.ratio      <= `PCG_RATIO_RESET;
      st.ratio_load <= 1'b1;
      st.periph_en  <= 1'b1;
      st.gpio_en    <= 1'b0;
      st.i2c_en     <= 1'b0;
      st.tmr2_en    <= 1'b0;
      st.gpio_tick  <= 1'b0;
      st.rdata      <= 32'h0000_0000;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ====================================================================
  // outputs

  assign o_rdata         = st.rdata;
  assign o_periph_clk_en = st.periph_en;
  assign o_gpio_clk_en   = st.gpio_tick;
  assign o_i2c_clk_en    = st.i2c_en;
  assign o_timer2_clk_en = st.tmr2_en;

endmodule

// ==== rtl/pcg_regs.svh ====
// pcg_regs.svh
// register map, field positions, reset values and counts of the clock gating block
// assumes a 32-bit byte-addressed register port with one aligned word per register
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// ====================================================================
// register addresses
`define PCG_GATE_ADDR      32'h4004C314
`define PCG_DIV_ADDR       32'h4004C310
`define PCG_STAT_ADDR      32'h4004C3F0

// ====================================================================
// gate register fields
`define PCG_GATE_W         6
`define PCG_ALL_BIT        5
`define PCG_GPIO_BIT       4
`define PCG_I2C_BIT        3
`define PCG_TMR2_BIT       2
`define PCG_GATE_RESET     6'h1F

// ====================================================================
// divider register fields
`define PCG_DIVCNT_LSB     16
`define PCG_DIVCNT_MSB     23
`define PCG_DIVCNT_RESET   8'h10
`define PCG_RATIO_MIN      6'h01
`define PCG_RATIO_MAX      6'h20
`define PCG_RATIO_RESET    6'h10

// ====================================================================
// status register fields
`define PCG_ST_PERIPH_BIT  0
`define PCG_ST_GPIO_BIT    1
`define PCG_ST_I2C_BIT     2
`define PCG_ST_TMR2_BIT    3
`define PCG_ST_HIB_BIT     4
`define PCG_ST_RATIO_LSB   8
`define PCG_ST_RATIO_MSB   13
`define PCG_ST_COUNT_LSB   16
`define PCG_ST_COUNT_MSB   23

`endif

// ==== rtl/pcg_pkg.sv ====
// pcg_pkg.sv
// types shared by the clock gating block and its divider
// assumes pcg_regs.svh is on the include path
package pcg_pkg;
  `include "pcg_regs.svh"

  // ====================================================================
  // power modes seen by the gating logic
  typedef enum logic [1:0] {
    PCG_ACTIVE,
    PCG_LOW_POWER_RUN,
    PCG_HIBERNATE
  } pcg_mode_t;

  // ====================================================================
  // state of the divider
  typedef struct packed {
    logic [5:0] count;
    logic [5:0] ratio;
    logic       tick;
  } pcg_div_state_t;

  // ====================================================================
  // state of the gating block
  typedef struct packed {
    logic [5:0]  gate;
    logic [7:0]  div_count;
    logic [5:0]  ratio;
    logic        ratio_load;
    logic        periph_en;
    logic        gpio_en;
    logic        i2c_en;
    logic        tmr2_en;
    logic        gpio_tick;
    logic [31:0] rdata;
  } pcg_state_t;
endpackage

// ==== rtl/pcg_divider.sv ====
// pcg_divider.sv
// auxiliary divider: one-cycle tick every ratio cycles of the root clock
// assumes the ratio is already saturated to 1..32 by the caller
`timescale 1ns/100ps

module pcg_divider
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // control
  input  wire logic       i_run,
  input  wire logic       i_load,
  input  wire logic [5:0] i_ratio,
  // divided rate
  output logic            o_tick
);

  pcg_div_state_t st;
  pcg_div_state_t next_st;

  // ====================================================================
  // counter
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (i_load)
    begin
      // restart so the new rate shows from the next period on
      next_st.ratio = i_ratio;
      next_st.count = 6'h00;
    end
    else if (i_run)
    begin
      if (st.count >= st.ratio - 6'h01)
      begin
        next_st.count = 6'h00;
        next_st.tick  = 1'b1;
      end
      else
      begin
        next_st.count = st.count + 6'h01;
      end
    end
    else
    begin
      next_st.count = 6'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st <= '{count: 6'h00, ratio: `PCG_RATIO_MAX >> 1, tick: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

endmodule

// ==== test/pcg_clock_gating_props.sv ====
// pcg_clock_gating_props.sv
// port assertions for pcg_clock_gating, bound in from the bench top
`timescale 1ns/100ps
`include "pcg_regs.svh"

module pcg_gating_props
  import pcg_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire pcg_mode_t   i_power_mode,
  input wire logic        i_periph_access,
  input wire logic        i_i2c_access,
  input wire logic        i_timer2_access,
  input wire logic        o_periph_clk_en,
  input wire logic        o_gpio_clk_en,
  input wire logic        o_i2c_clk_en,
  input wire logic        o_timer2_clk_en
);
  logic run;
  assign run = i_power_mode != PCG_HIBERNATE;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ====================================================================
  // sequences
  sequence quiet_s;
    run && !i_wr && !i_rd;
  endsequence
  sequence i2c_hit_s;
    i_i2c_access && o_periph_clk_en && run && !i_wr ##1 quiet_s;
  endsequence
  sequence tmr_hit_s;
    i_timer2_access && o_periph_clk_en && run && !i_wr ##1 quiet_s;
  endsequence
  sequence all_off_s;
    i_wr && i_addr == `PCG_GATE_ADDR && i_wdata[5] && o_periph_clk_en && run
    ##1 run && !i_wr && !i_rd && !i_periph_access && !i_i2c_access && !i_timer2_access;
  endsequence
  // ====================================================================
  // checks
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  gate_read_a: assert property ($past(i_rd) && $past(i_addr) == `PCG_GATE_ADDR
    |-> o_rdata[31:5] == 27'h0) else $error("gate register upper bits not zero");
  hib_off_a: assert property (!run [*2] |=> !o_periph_clk_en && !o_gpio_clk_en
    && !o_i2c_clk_en && !o_timer2_clk_en) else $error("clock running in hibernate");
  global_set_a: assert property (all_off_s |=> !o_periph_clk_en && !o_i2c_clk_en
    && !o_timer2_clk_en) else $error("global gate did not stop clocks");
  global_clr_a: assert property (i_periph_access && !o_periph_clk_en && run && $past(run)
    ##1 quiet_s |=> o_periph_clk_en) else $error("access did not reopen clocks");
  i2c_clear_a: assert property (i2c_hit_s |=> o_i2c_clk_en)
    else $error("i2c access did not open its clock");
  tmr_clear_a: assert property (tmr_hit_s |=> o_timer2_clk_en)
    else $error("timer access did not open its clock");
  needs_global_a: assert property (o_i2c_clk_en || o_timer2_clk_en |-> o_periph_clk_en)
    else $error("clock running with global gate closed");
endmodule

// ==== test/pcg_clock_gating_bench.sv ====
// pcg_clock_gating_bench.sv
// self-checking bench; drives every port of pcg_clock_gating directly
`timescale 1ns/100ps
`include "pcg_regs.svh"

module pcg_clock_gating_bench;
  import pcg_pkg::*;
  localparam logic [31:0] G = `PCG_GATE_ADDR;
  localparam logic [31:0] V = `PCG_DIV_ADDR;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [31:0] i_addr = 32'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  pcg_mode_t   i_power_mode = PCG_ACTIVE;
  logic        i_periph_access = 1'b0;
  logic        i_i2c_access = 1'b0;
  logic        i_timer2_access = 1'b0;
  logic [31:0] o_rdata;
  logic        o_periph_clk_en, o_gpio_clk_en, o_i2c_clk_en, o_timer2_clk_en;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          c;
  logic [31:0] d;

  pcg_clock_gating dut (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_power_mode, .i_periph_access, .i_i2c_access, .i_timer2_access, .o_periph_clk_en,
    .o_gpio_clk_en, .o_i2c_clk_en, .o_timer2_clk_en);

  always #4 i_clk = ~i_clk;

  // a hang counts as a mismatch and ends the run
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  // ====================================================================
  // shared tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ce(input logic [2:0] e);
    chk("enables", {29'h0, e}, {29'h0, o_periph_clk_en, o_i2c_clk_en, o_timer2_clk_en});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic acc(input int k);
    @(posedge i_clk);
    i_periph_access <= (k == 0);
    i_i2c_access <= (k == 1);
    i_timer2_access <= (k == 2);
    @(posedge i_clk);
    {i_periph_access, i_i2c_access, i_timer2_access} <= 3'b000;
    wait_n(2);
  endtask
  task automatic pulses(input int n);
    c = 0;
    repeat (n)
    begin
      @(posedge i_clk);
      #1 c += int'(o_gpio_clk_en === 1'b1);
    end
    chk("gpio pulses", 32'h0, 32'(c));
  endtask
  // the first two gaps may straddle a divider restart
  task automatic rate(input int n);
    repeat (3)
    begin
      c = 0;
      do
      begin
        @(posedge i_clk);
        #1 c++;
      end
      while (o_gpio_clk_en !== 1'b1 && c < 100);
    end
    chk("gpio period", 32'(n), 32'(c));
  endtask
  // ====================================================================
  // scenarios
  task automatic t_basic();
    rd(G);
    chk("gate", 32'h1F, d);
    ce(3'b100);
    wr(G, 32'h3);
    wait_n(2);
    ce(3'b111);
    rd(G);
    chk("gate", 32'h3, d);
    wr(G, 32'hB);
    wait_n(2);
    ce(3'b101);
    wr(G, 32'h7);
    wait_n(2);
    ce(3'b110);
    $display("test basic done");
  endtask
  task automatic t_global();
    wr(G, 32'h0);
    wr(G, 32'h20);
    wait_n(2);
    ce(3'b000);
    pulses(40);
    rd(G);
    chk("gate", 32'h0, d);
    wait_n(2);
    ce(3'b111);
    wr(G, 32'h20);
    wait_n(2);
    acc(0);
    ce(3'b111);
    $display("test global done");
  endtask
  task automatic t_access();
    wr(G, 32'hC);
    wait_n(2);
    ce(3'b100);
    acc(1);
    ce(3'b110);
    acc(2);
    ce(3'b111);
    wr(G, 32'h10);
    acc(0);
    acc(1);
    acc(2);
    rd(G);
    chk("gate", 32'h10, d);
    $display("test access done");
  endtask
  task automatic t_hib();
    wr(G, 32'h0);
    @(posedge i_clk);
    i_power_mode <= PCG_HIBERNATE;
    wait_n(3);
    ce(3'b000);
    pulses(40);
    wr(G, 32'hC);
    i_power_mode <= PCG_LOW_POWER_RUN;
    wait_n(3);
    ce(3'b111);
    rd(G);
    chk("gate", 32'h0, d);
    rate(16);
    @(posedge i_clk);
    i_power_mode <= PCG_ACTIVE;
    $display("test hibernate done");
  endtask
  task automatic t_div();
    logic [7:0] k[5] = '{8'h04, 8'h00, 8'h01, 8'h40, 8'h20};
    int         r[5] = '{4, 1, 1, 32, 32};
    foreach (k[i])
    begin
      wr(V, {8'h0, k[i], 16'h0});
      rate(r[i]);
    end
    wr(G, 32'h10);
    wr(V, 32'h00020000);
    pulses(40);
    rd(`PCG_STAT_ADDR);
    chk("ratio", 32'd32, {26'h0, d[13:8]});
    wr(G, 32'h0);
    rate(32);
    rd(32'h4004C400);
    chk("unmapped", 32'h0, d);
    $display("test divider done");
  endtask

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_basic();
    t_global();
    t_access();
    t_hib();
    t_div();
    finish_test();
  end
endmodule

bind pcg_clock_gating pcg_gating_props u_props (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_power_mode, .i_periph_access, .i_i2c_access, .i_timer2_access,
  .o_periph_clk_en, .o_gpio_clk_en, .o_i2c_clk_en, .o_timer2_clk_en);
